// ==== hdl/rate_sample_output_regs.sv ====
/*
 * read side of the angular rate output registers 0x00..0x07.
 * assumes the serial port logic runs on core_clk, issues one-cycle
 * read strobes, and that acquisition and fifo logic sit beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module rate_sample_output_regs
    import rso_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic rdStrobe,
    input wire logic [7:0] rdAddr,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic [7:0] nextAddr,
    input wire logic wrapSelectBit,
    input wire logic [1:0] fifoMode,
    input wire logic [7:0] fifoStatus,
    input wire logic [1:0] opMode,
    input wire logic [AXES-1:0] axisDone,
    input wire logic [AXES-1:0][SAMPLE_W-1:0] axisSample,
    input wire logic [AXES-1:0][SAMPLE_W-1:0] fifoHead,
    output logic fifoPop,
    output logic [7:0] readyFlags
);
    rso_flag_if fl();

    logic [SAMPLE_W-1:0] liveR [AXES];
    logic [7:0] outR [6];
    logic [1:0] opModeR;
    logic liveMode, rdHit;
    logic [7:0] rdData_nxt, nextAddr_nxt;
    logic [2:0] hiRead;

    // ************************************
    // decode
    // ************************************
    assign liveMode = (fifoMode == FIFO_MODE_OFF);
    assign rdHit = clkEn && rdStrobe;

    genvar a;
    generate
        for (a = 0; a < AXES; a++) begin : g_axis
            localparam logic [7:0] HI_ADDR = ADDR_X_HI + 8'(2 * a);
            assign hiRead[a] = rdHit && (rdAddr == HI_ADDR);

            // live sample per axis, refreshed at the output rate
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    liveR[a] <= {SAMPLE_W{1'b0}};
                end else if (clkEn && axisDone[a]) begin
                    liveR[a] <= axisSample[a];
                end
            end
        end
    endgenerate

    assign fl.axisDone = clkEn ? axisDone : 3'h0;
    assign fl.hiRead = hiRead;
    assign fl.modeClear = (opMode == OPMODE_ACTIVE)
        && (opModeR == OPMODE_STANDBY || opModeR == OPMODE_READY);

    rso_status_flags u_flags (
        .core_clk(core_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .fl(fl.flagSide)
    );

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            opModeR <= OPMODE_STANDBY;
        end else if (clkEn) begin
            opModeR <= opMode;
        end
    end

    // ************************************
    // byte snapshot
    // ************************************
    // the low byte is frozen at the high read, so a sample landing
    // mid-read cannot tear the pair
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 6; i++) begin
                outR[i] <= RESET_BYTE;
            end
        end else if (rdHit) begin
            if (liveMode) begin
                for (int i = 0; i < AXES; i++) begin
                    if (hiRead[i]) begin
                        outR[2*i] <= liveR[i][15:8];
                        outR[2*i+1] <= liveR[i][7:0];
                    end
                end
            end else if (hiRead[0]) begin
                for (int i = 0; i < AXES; i++) begin
                    outR[2*i] <= fifoHead[i][15:8];
                    outR[2*i+1] <= fifoHead[i][7:0];
                end
            end
        end
    end

    // ************************************
    // read mux and auto-increment
    // ************************************
    always_comb begin
        rdData_nxt = RESET_BYTE;
        if (rdAddr == ADDR_STATUS) begin
            rdData_nxt = liveMode ? fl.flags : fifoStatus;
        end else if (rdAddr == ADDR_READY_FLAGS) begin
            rdData_nxt = fl.flags;
        end else if (rdAddr == ADDR_X_HI) begin
            rdData_nxt = liveMode ? liveR[0][15:8] : fifoHead[0][15:8];
        end else if (rdAddr >= ADDR_X_LO && rdAddr <= ADDR_Z_LO) begin
            rdData_nxt = outR[3'(rdAddr - ADDR_X_HI)];
            for (int i = 1; i < AXES; i++) begin
                if (liveMode && hiRead[i]) begin
                    rdData_nxt = liveR[i][15:8];
                end
            end
        end
    end

    always_comb begin
        nextAddr_nxt = rdAddr + 8'h01;
        if (rdAddr == ADDR_Z_LO) begin
            nextAddr_nxt = wrapSelectBit ? ADDR_X_HI : ADDR_STATUS;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= RESET_BYTE;
            rdValid <= 1'b0;
            nextAddr <= ADDR_STATUS;
        end else if (clkEn) begin
            rdValid <= rdStrobe;
            if (rdStrobe) begin
                rdData <= rdData_nxt;
                nextAddr <= nextAddr_nxt;
            end
        end
    end

    // the head advances only on the z high read, so a host that
    // stops mid-burst re-reads the same head entry
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fifoPop <= 1'b0;
        end else if (clkEn) begin
            fifoPop <= rdStrobe && !liveMode && rdAddr == ADDR_Z_HI;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            readyFlags <= RESET_BYTE;
        end else if (clkEn) begin
            readyFlags <= fl.flags;
        end
    end

    property p_pop;
        @(posedge core_clk) disable iff (!rstn)
        rdHit && !liveMode && rdAddr == ADDR_Z_HI |=> fifoPop;
    endproperty
    a_pop: assert property (p_pop)
        else $error("fifo pop missing on z high read");

    property p_no_pop;
        @(posedge core_clk) disable iff (!rstn)
        clkEn && !(rdStrobe && !liveMode && rdAddr == ADDR_Z_HI)
        |=> !fifoPop;
    endproperty
    a_no_pop: assert property (p_no_pop)
        else $error("fifo pop without z high read");

    property p_wrap;
        @(posedge core_clk) disable iff (!rstn)
        rdHit && rdAddr == ADDR_Z_LO
        |=> nextAddr == ($past(wrapSelectBit) ? ADDR_X_HI : ADDR_STATUS);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("auto-increment wrap wrong");

    property p_lo_latch;
        @(posedge core_clk) disable iff (!rstn)
        rdHit && liveMode && rdAddr == ADDR_X_HI
        |=> outR[1] == $past(liveR[0][7:0]);
    endproperty
    a_lo_latch: assert property (p_lo_latch)
        else $error("x low byte not latched on high read");

    property p_status_alias;
        @(posedge core_clk) disable iff (!rstn)
        rdHit && rdAddr == ADDR_STATUS
        |=> rdValid && rdData == ($past(liveMode) ? $past(fl.flags)
            : $past(fifoStatus));
    endproperty
    a_status_alias: assert property (p_status_alias)
        else $error("status alias returned wrong byte");

    property p_fifo_load;
        @(posedge core_clk) disable iff (!rstn)
        rdHit && !liveMode && rdAddr == ADDR_X_HI
        |=> outR[5] == $past(fifoHead[2][7:0]);
    endproperty
    a_fifo_load: assert property (p_fifo_load)
        else $error("z low byte not loaded from fifo head");

    // y high bypasses the snapshot, so both halves are checked here
    property p_pair;
        @(posedge core_clk) disable iff (!rstn)
        rdHit && liveMode && hiRead[1]
        |=> rdData == $past(liveR[1][15:8])
            && outR[3] == $past(liveR[1][7:0]);
    endproperty
    a_pair: assert property (p_pair)
        else $error("y bytes taken from different samples");

    property p_flags_copy;
        @(posedge core_clk) disable iff (!rstn)
        clkEn |=> readyFlags == $past(fl.flags);
    endproperty
    a_flags_copy: assert property (p_flags_copy)
        else $error("ready flag copy does not follow status");
endmodule
`default_nettype wire

// ==== hdl/rso_pkg.sv ====
/*
 * constants for the rate sample output register bank: addresses,
 * status bit positions, mode codes and reset values.
 * assumes one core clock; register offsets are the serial port's
 * byte addresses as seen by the host.
 */
// Functional notes
// - each axis is 16-bit two's complement, two bytes
// - six bytes big-endian at 0x01 to 0x06
// - fifo mode zero live samples, else fifo head
// - live mode: high byte read latches low byte
// - fifo mode: x high read loads other five
// - fifo pointer advances only on z high read
// - after z low, wrap to 0x00 or 0x01
// - sample registers read-only, zero after power-on
// - status clears on standby/ready to active
// - status layout: overwrites 7..4, readies 3..0
// - combined overwrite on new set before retrieval
// - combined overwrite clears after all high reads
// - axis overwrite sets on unread data, clears on read
// - axis ready sets on acquisition, clears on read
// - combined ready sets any, clears all high reads
// - address zero mirrors ready or fifo status
package rso_pkg;
    localparam int AXES = 3;
    localparam int SAMPLE_W = 16;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_X_HI = 8'h01;
    localparam logic [7:0] ADDR_X_LO = 8'h02;
    localparam logic [7:0] ADDR_Y_HI = 8'h03;
    localparam logic [7:0] ADDR_Z_HI = 8'h05;
    localparam logic [7:0] ADDR_Z_LO = 8'h06;
    localparam logic [7:0] ADDR_READY_FLAGS = 8'h07;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int BIT_ALL_OW = 7;
    localparam int BIT_OW_LSB = 4;
    localparam int BIT_ANY_RDY = 3;
    localparam int BIT_RDY_LSB = 0;
    localparam logic [1:0] FIFO_MODE_OFF = 2'h0;
    localparam logic [1:0] OPMODE_STANDBY = 2'h0;
    localparam logic [1:0] OPMODE_READY = 2'h1;
    localparam logic [1:0] OPMODE_ACTIVE = 2'h2;
endpackage

// ==== hdl/rso_flag_if.sv ====
/*
 * carrier between the register bank and its status flag keeper.
 * assumes both ends run on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface rso_flag_if;
    logic [2:0] axisDone;
    logic [2:0] hiRead;
    logic modeClear;
    logic [7:0] flags;
    modport bankSide(output axisDone, output hiRead, output modeClear,
        input flags);
    modport flagSide(input axisDone, input hiRead, input modeClear,
        output flags);
endinterface
`default_nettype wire

// ==== hdl/rso_status_flags.sv ====
/*
 * keeps the ready and overwrite status byte.
 * assumes acquisition and read pulses are one core_clk cycle wide.
 */
`timescale 1ns/1ps
`default_nettype none
module rso_status_flags
    import rso_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clkEn,
    rso_flag_if.flagSide fl
);
    logic [2:0] rdyR, owR, seenR, doneAccR;
    logic anyRdyR, allOwR;
    logic [2:0] seenNxt, doneNxt;
    logic allRead, setComplete;

    assign seenNxt = seenR | fl.hiRead;
    assign allRead = &seenNxt;
    assign doneNxt = doneAccR | fl.axisDone;
    assign setComplete = &doneNxt;

    // ************************************
    // per-axis flags
    // ************************************
    // set wins over the read clear so no acquisition is lost
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdyR <= 3'h0;
            owR <= 3'h0;
        end else if (clkEn) begin
            if (fl.modeClear) begin
                rdyR <= 3'h0;
                owR <= 3'h0;
            end else begin
                rdyR <= (rdyR & ~fl.hiRead) | fl.axisDone;
                owR <= (owR & ~fl.hiRead) | (fl.axisDone & rdyR);
            end
        end
    end

    // ************************************
    // combined flags
    // ************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            anyRdyR <= 1'b0;
            allOwR <= 1'b0;
            seenR <= 3'h0;
            doneAccR <= 3'h0;
        end else if (clkEn) begin
            if (fl.modeClear) begin
                anyRdyR <= 1'b0;
                allOwR <= 1'b0;
                seenR <= 3'h0;
                doneAccR <= 3'h0;
            end else begin
                seenR <= allRead ? 3'h0 : seenNxt;
                doneAccR <= setComplete ? 3'h0 : doneNxt;
                anyRdyR <= (|fl.axisDone) | (anyRdyR & ~allRead);
                allOwR <= (setComplete & anyRdyR)
                    | (allOwR & ~allRead);
            end
        end
    end

    assign fl.flags = {allOwR, owR, anyRdyR, rdyR};

    property p_rdy_set;
        @(posedge core_clk) disable iff (!rstn)
        clkEn && !fl.modeClear && fl.axisDone[0] |=> fl.flags[BIT_RDY_LSB];
    endproperty
    a_rdy_set: assert property (p_rdy_set)
        else $error("x ready not set after acquisition");

    property p_ow_set;
        @(posedge core_clk) disable iff (!rstn)
        clkEn && !fl.modeClear && fl.axisDone[2] && fl.flags[2]
        |=> fl.flags[BIT_OW_LSB + 2];
    endproperty
    a_ow_set: assert property (p_ow_set)
        else $error("z overwrite not set on unread data");

    property p_mode_clear;
        @(posedge core_clk) disable iff (!rstn)
        clkEn && fl.modeClear |=> fl.flags == RESET_BYTE;
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("status not cleared on mode entry");

    property p_any_clear;
        @(posedge core_clk) disable iff (!rstn)
        clkEn && !fl.modeClear && fl.axisDone == 3'h0 && allRead
        |=> !fl.flags[BIT_ANY_RDY] && !fl.flags[BIT_ALL_OW];
    endproperty
    a_any_clear: assert property (p_any_clear)
        else $error("combined flags survive full high-byte read");
endmodule
`default_nettype wire

// ==== tb/rso_sample_source.sv ====
/*
 * sample source model: per-axis acquisitions and a fifo head
 * that steps on each pop. assumes core_clk and rstn of the bank.
 */
`timescale 1ns/1ps
`default_nettype none
module rso_sample_source
    import rso_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic acqReq,
    input wire logic [15:0] acqBase,
    input wire logic fifoPop,
    output logic [AXES-1:0] axisDone,
    output logic [AXES-1:0][SAMPLE_W-1:0] axisSample,
    output logic [AXES-1:0][SAMPLE_W-1:0] fifoHead
);
    logic [3:0] headIdx_r;
    // ***************
    // acquisition
    // ***************
    // samples stand until the next acquisition, like a real converter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            axisDone <= '0;
            axisSample <= '0;
        end else begin
            axisDone <= acqReq ? 3'h7 : 3'h0;
            if (acqReq) begin
                axisSample[0] <= acqBase;
                axisSample[1] <= acqBase + 16'h1111;
                axisSample[2] <= acqBase + 16'h2222;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            headIdx_r <= 4'h0;
        end else if (fifoPop) begin
            headIdx_r <= headIdx_r + 4'h1;
        end
    end
    // head entry n: high byte a0+16n+axis, low byte 50+16n+axis
    always_comb begin
        for (int i = 0; i < AXES; i++) begin
            fifoHead[i][15:8] = 8'ha0 + 8'(i) + {headIdx_r, 4'h0};
            fifoHead[i][7:0] = 8'h50 + 8'(i) + {headIdx_r, 4'h0};
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 * self-checking bench for the rate sample output registers.
 * assumes the sample source model feeds acquisitions and fifo head.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rso_pkg::*;
;
    logic core_clk;
    logic rstn;
    logic clkEn;
    logic rdStrobe;
    logic [7:0] rdAddr;
    logic [7:0] rdData;
    logic rdValid;
    logic [7:0] nextAddr;
    logic wrapSelectBit;
    logic [1:0] fifoMode;
    logic [7:0] fifoStatus;
    logic [1:0] opMode;
    logic [AXES-1:0] axisDone;
    logic [AXES-1:0][SAMPLE_W-1:0] axisSample;
    logic [AXES-1:0][SAMPLE_W-1:0] fifoHead;
    logic fifoPop;
    logic [7:0] readyFlags;
    logic acqReq;
    logic [15:0] acqBase;
    int fails;
    int checksDone;
    rate_sample_output_regs u_rate_sample_output_regs(.core_clk(core_clk),
        .rstn(rstn), .clkEn(clkEn), .rdStrobe(rdStrobe), .rdAddr(rdAddr),
        .rdData(rdData), .rdValid(rdValid), .nextAddr(nextAddr),
        .wrapSelectBit(wrapSelectBit), .fifoMode(fifoMode),
        .fifoStatus(fifoStatus), .opMode(opMode), .axisDone(axisDone),
        .axisSample(axisSample), .fifoHead(fifoHead), .fifoPop(fifoPop),
        .readyFlags(readyFlags));
    rso_sample_source u_rso_sample_source(.core_clk(core_clk), .rstn(rstn),
        .acqReq(acqReq), .acqBase(acqBase), .fifoPop(fifoPop),
        .axisDone(axisDone), .axisSample(axisSample), .fifoHead(fifoHead));
    always #2.5 core_clk = ~core_clk;
    // ***************
    // host access tasks
    // ***************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one idle cycle between strobes keeps each assignment in its own step
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        int k;
        @(posedge core_clk);
        #1;
        rdAddr = a;
        rdStrobe = 1'b1;
        @(posedge core_clk);
        #1;
        rdStrobe = 1'b0;
        k = 0;
        while (rdValid !== 1'b1 && k < 4) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        if (k == 4) begin
            fails++;
            print_verdict();
        end else begin
            q = rdData;
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        rd(a, q);
        chk($sformatf("reg %h", a), q, exp);
    endtask
    task automatic acq(input logic [15:0] base);
        @(posedge core_clk);
        #1;
        acqBase = base;
        acqReq = 1'b1;
        @(posedge core_clk);
        #1;
        acqReq = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    // host always starts at x high and takes all six bytes in a row
    task automatic burst(input logic [7:0] e [6], input logic [7:0] wrapTo);
        logic [7:0] q;
        for (int a = 1; a <= 6; a++) begin
            rd(8'(a), q);
            chk("sample byte", q, e[a-1]);
            chk("nextAddr", nextAddr, (a == 6) ? wrapTo : 8'(a + 1));
            chk("fifoPop", 8'(fifoPop),
                8'(fifoMode != FIFO_MODE_OFF && a == 5));
        end
    endtask
    // ***************
    // scenarios
    // ***************
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        clkEn = 1'b1;
        rdStrobe = 1'b0;
        rdAddr = 8'h00;
        wrapSelectBit = 1'b0;
        fifoMode = FIFO_MODE_OFF;
        fifoStatus = 8'h5a;
        opMode = OPMODE_ACTIVE;
        acqReq = 1'b0;
        acqBase = 16'h0000;
        fails = 0;
        checksDone = 0;
        repeat (12) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        for (int a = 0; a <= 8; a++) begin
            rc(8'(a), 8'h00);
        end
        acq(16'h8a01);
        chk("readyFlags", readyFlags, 8'h0f);
        rc(ADDR_STATUS, 8'h0f);
        burst('{8'h8a, 8'h01, 8'h9b, 8'h12, 8'hac, 8'h23}, 8'h00);
        rc(ADDR_READY_FLAGS, 8'h00);
        rc(ADDR_X_HI, 8'h8a);
        acq(16'h1357);
        rc(ADDR_X_LO, 8'h01);
        rc(ADDR_X_HI, 8'h13);
        rc(ADDR_X_LO, 8'h57);
        rc(ADDR_Y_HI, 8'h24);
        rc(ADDR_Z_HI, 8'h35);
        acq(16'h0102);
        acq(16'h0304);
        rc(ADDR_READY_FLAGS, 8'hff);
        rc(ADDR_X_HI, 8'h03);
        rc(ADDR_READY_FLAGS, 8'hee);
        rc(ADDR_Y_HI, 8'h14);
        rc(ADDR_Z_HI, 8'h25);
        rc(ADDR_READY_FLAGS, 8'h00);
        for (int m = 0; m < 2; m++) begin
            acq(16'h0000);
            chk("readyFlags", readyFlags, 8'h0f);
            opMode = (m == 0) ? OPMODE_STANDBY : OPMODE_READY;
            repeat (2) @(posedge core_clk);
            #1;
            opMode = OPMODE_ACTIVE;
            repeat (3) @(posedge core_clk);
            #1;
            rc(ADDR_READY_FLAGS, 8'h00);
        end
        // a frozen bank must miss an acquisition entirely
        clkEn = 1'b0;
        acq(16'h7777);
        clkEn = 1'b1;
        chk("readyFlags", readyFlags, 8'h00);
        rc(ADDR_X_HI, 8'h00);
        fifoMode = 2'h1;
        wrapSelectBit = 1'b1;
        rc(ADDR_STATUS, 8'h5a);
        burst('{8'ha0, 8'h50, 8'ha1, 8'h51, 8'ha2, 8'h52}, 8'h01);
        burst('{8'hb0, 8'h60, 8'hb1, 8'h61, 8'hb2, 8'h62}, 8'h01);
        print_verdict();
    end
endmodule
`default_nettype wire
